// File: led_drive_regs.svh
// Constants for the LED illumination drive sequencer.
// Assumes inclusion by the package; the design module uses its macros without including it.
`ifndef LED_DRIVE_REGS_SVH
`define LED_DRIVE_REGS_SVH

// Setting widths
`define FB_DAC_W        12
`define LIM_DAC_W       10
`define GAIN_SEL_W      4
`define TRIM_W          4
`define LED_CHANNEL_SELECT_W       4
`define OFF_CNT_W       8
// Gain steps available and trim code of one fifth
`define GAIN_STEPS      14
`define TRIM_FULL       4'hF
`define TRIM_MIN        4'h0
// Reset values
`define OFF_LEN_RST     8'h10

`endif

// File: led_drive_pkg.sv
// Types for the LED illumination drive sequencer.
// Assumes led_drive_regs.svh is on the include path.
`include "led_drive_regs.svh"

package led_drive_pkg;

  // Per-colour settings bundle
  typedef struct packed {
    logic [`FB_DAC_W-1:0]  fb_ref;
    logic [`LIM_DAC_W-1:0] limit;
    logic [`TRIM_W-1:0]    trim;
  } color_set_t;

  // Gate drive bundle toward the external FETs
  typedef struct packed {
    logic [`LED_CHANNEL_SELECT_W-1:0] led_channel_select;
    logic                  low_res_shunt_enable;
    logic                  dissipative_shunt_enable;
  } gate_drive_t;

  // Drive control states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DISSIPATE,
    ST_PRECHARGE,
    ST_HYSTERETIC,
    ST_FORCED_OFF,
    ST_PULSED
  } drive_state_t;

endpackage : led_drive_pkg

// File: led_illumination_drive_sequencer.sv
// LED illumination drive sequencer: hysteretic drive, blanking, pulsed.
// Assumes a 100 MHz clock; the comparator and limit-reached inputs are
// asynchronous pins and are synchronised here.
//
// Operation
// - Light below threshold means comparator high, drive enable high.
// - Light above threshold drops drive enable at once.
// - Drive enable follows comparator while the LED circuit stays enabled.
// - Steady-light operation holds capacitance select low.
// - Pulsed-light operation drives capacitance select high.
// - Amp gain select encodes at least fourteen steps.
// - Per-colour amp gain trim spans full scale to one fifth.
// - Peak limit DAC setting is ten bits.
// - Feedback reference is twelve bits, used in both modes.
// - Sync output overrides buck off-time; drive enable enables buck.
// - Dissipative shunt phase with all LEDs off discharges inductor.
// - Low-resistance shunt phase charges inductor to peak limit.
// - End of blanking: release shunt, select LED, toggle drive, hysteretic, or pulsed in pulsed operation.
// - Limit is pre-charge current pulsed, maximum LED current steady.
// - Comparator threshold reached starts programmable constant-off counter.
// - During forced-off interval comparator ignored, drive held low.
// - Pulsed operation turns drive on at drive request; here ST_PULSED drive follows the comparator.
`timescale 1ns/100ps

module led_illumination_drive_sequencer
  import led_drive_pkg::*;
#(
  parameter int COLORS = 4
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_pulsed_light_operation,
  input  wire logic [`OFF_CNT_W-1:0]  i_off_len,
  input  wire logic [`GAIN_SEL_W-1:0] i_gain_sel,
  input  wire color_set_t             i_color_set [COLORS],
  input  wire gate_drive_t            i_gate_req,
  input  wire logic                   i_drive_request,
  input  wire logic                   i_comparator,
  input  wire logic                   i_limit_reached,
  output logic                        o_buck_drive_enable,
  output logic                        o_sync,
  output logic                        o_output_cap_select,
  output gate_drive_t                 o_gate_drive,
  output logic [`FB_DAC_W-1:0]        o_fb_dac,
  output logic [`LIM_DAC_W-1:0]       o_peak_limit_dac,
  output logic [`TRIM_W-1:0]          o_gain_trim,
  output logic [`GAIN_SEL_W-1:0]      o_primary_photo_amp_gain,
  output logic                        o_forced_off_interval,
  output drive_state_t                o_state
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // One colour per select bit, so no more colours than select bits
  if (COLORS < 1 || COLORS > `LED_CHANNEL_SELECT_W) begin : g_bad_colors
    $error("COLORS out of range");
  end
  if ((1 << `GAIN_SEL_W) < `GAIN_STEPS) begin : g_bad_gain
    $error("gain select too narrow");
  end

  // Index of the lowest active select bit, zero if none
  function automatic int unsigned sel_index(
    input logic [`LED_CHANNEL_SELECT_W-1:0] sel);
    int unsigned idx;
    idx = 0;
    for (int i = `LED_CHANNEL_SELECT_W - 1; i >= 0; i--) begin
      if (sel[i])
        idx = i;
    end
    return idx;
  endfunction : sel_index

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic cmp_meta;
  logic cmp_sync;
  logic lim_meta;
  logic lim_sync;

  // Two flops per asynchronous pin
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
      lim_meta <= 1'b0;
      lim_sync <= 1'b0;
    end else begin
      cmp_meta <= i_comparator;
      cmp_sync <= cmp_meta;
      lim_meta <= i_limit_reached;
      lim_sync <= lim_meta;
    end
  end

  // ---------------------------------------------------------------
  // Drive state machine
  // ---------------------------------------------------------------
  drive_state_t          state;
  drive_state_t          next_state;
  logic [`OFF_CNT_W-1:0] off_cnt;
  logic [`OFF_CNT_W-1:0] next_off_cnt;
  logic                  drive;
  logic                  next_drive;
  logic                  sync_ovr;
  logic                  next_sync_ovr;

  // Next state, counter and drive
  always_comb begin
    next_state    = state;
    next_off_cnt  = off_cnt;
    next_drive    = 1'b0;
    next_sync_ovr = 1'b0;
    case (state)
      ST_IDLE: begin
        if (i_gate_req.dissipative_shunt_enable)
          next_state = ST_DISSIPATE;
        else if (i_gate_req.low_res_shunt_enable && i_drive_request)
          next_state = ST_PRECHARGE;
        else if (i_drive_request)
          next_state = i_pulsed_light_operation ? ST_PULSED
                                                : ST_HYSTERETIC;
      end
      ST_DISSIPATE: begin
        // Drive stays off while residual energy dissipates
        if (!i_gate_req.dissipative_shunt_enable)
          next_state = ST_IDLE;
      end
      ST_PRECHARGE: begin
        // charge into shunt until the peak limit is met
        next_drive = !lim_sync;
        if (!i_drive_request)
          next_state = ST_IDLE;
        // shunt released, hand over to hysteretic loop, or to ST_PULSED in pulsed operation
        else if (!i_gate_req.low_res_shunt_enable)
          next_state = i_pulsed_light_operation ? ST_PULSED
                                                : ST_HYSTERETIC;
      end
      ST_HYSTERETIC: begin
        next_drive = cmp_sync;
        if (!i_drive_request) begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        // threshold reached starts the off counter
        end else if (!cmp_sync && drive) begin
          next_state    = ST_FORCED_OFF;
          next_off_cnt  = i_off_len;
        end
      end
      ST_FORCED_OFF: begin
        if (!i_drive_request)
          next_state = ST_IDLE;
        else if (off_cnt == '0)
          next_state = ST_HYSTERETIC;
        else
          next_off_cnt = off_cnt - 1'b1;
      end
      ST_PULSED: begin
        // drive follows the comparator until drive request drops
        next_drive = cmp_sync;
        if (!i_drive_request) begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (next_state == ST_IDLE || next_state == ST_DISSIPATE)
      next_drive = 1'b0;
    // sync override stands exactly while the off interval runs
    next_sync_ovr = (next_state == ST_FORCED_OFF);
  end

  // State registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state    <= ST_IDLE;
      off_cnt  <= '0;
      drive    <= 1'b0;
      sync_ovr <= 1'b0;
    end else begin
      state    <= next_state;
      off_cnt  <= next_off_cnt;
      drive    <= next_drive;
      sync_ovr <= next_sync_ovr;
    end
  end

  // ---------------------------------------------------------------
  // Per-colour settings and gate outputs
  // ---------------------------------------------------------------
  color_set_t  cur_set;
  color_set_t  next_cur_set;
  gate_drive_t gate;
  gate_drive_t next_gate;
  logic        cap_sel;
  logic        next_cap_sel;

  // Setting mux and pass-through
  always_comb begin
    int unsigned idx;
    idx = sel_index(i_gate_req.led_channel_select);
    if (idx < COLORS)
      next_cur_set = i_color_set[idx];
    else
      next_cur_set = i_color_set[0];
    next_gate = i_gate_req;
    next_cap_sel = i_pulsed_light_operation;
  end

  // Output setting registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      cur_set <= '0;
      gate    <= '0;
      cap_sel <= 1'b0;
    end else begin
      cur_set <= next_cur_set;
      gate    <= next_gate;
      cap_sel <= next_cap_sel;
    end
  end

  logic [`GAIN_SEL_W-1:0] gain;
  logic [`GAIN_SEL_W-1:0] next_gain;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // drive enable and sync override
  assign o_buck_drive_enable      = drive;
  assign o_sync                   = sync_ovr;
  assign o_output_cap_select      = cap_sel;
  assign o_gate_drive             = gate;
  // DAC settings, limit serves both modes
  assign o_fb_dac                 = cur_set.fb_ref;
  assign o_peak_limit_dac         = cur_set.limit;
  // trim code, full scale to one fifth
  assign o_gain_trim              = cur_set.trim;
  assign o_primary_photo_amp_gain = gain;
  assign o_forced_off_interval    = sync_ovr;
  assign o_state                  = state;

  // Gain steps beyond the last are clamped
  always_comb begin
    if (i_gain_sel >= `GAIN_SEL_W'(`GAIN_STEPS))
      next_gain = `GAIN_SEL_W'(`GAIN_STEPS - 1);
    else
      next_gain = i_gain_sel;
  end

  // Gain register
  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      gain <= '0;
    else
      gain <= next_gain;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_off_start;
    state == ST_HYSTERETIC && i_drive_request && !cmp_sync && drive;
  endsequence

  chk_drive_high_cmp: assert property (
    state == ST_HYSTERETIC && i_drive_request && cmp_sync
    |=> drive) else $error("drive not high with comparator high");
  chk_drive_low_cmp: assert property (
    s_off_start |=> !drive && state == ST_FORCED_OFF)
    else $error("drive not dropped at threshold");
  chk_forced_off_low: assert property (
    state == ST_FORCED_OFF |-> !drive && o_forced_off_interval)
    else $error("drive on during forced off");
  chk_off_count_load: assert property (
    s_off_start |=> off_cnt == $past(i_off_len))
    else $error("off counter not loaded");
  chk_cap_mode: assert property (
    !$past(i_rst) && $past(i_pulsed_light_operation)
    |-> o_output_cap_select)
    else $error("cap select wrong in pulsed mode");
  chk_cap_steady: assert property (
    !$past(i_rst) && !$past(i_pulsed_light_operation)
    |-> !o_output_cap_select)
    else $error("cap select wrong in steady mode");
  chk_dissipate_off: assert property (
    state == ST_DISSIPATE |-> !drive)
    else $error("drive on during dissipation");
  chk_precharge_stop: assert property (
    state == ST_PRECHARGE && i_drive_request && lim_sync
    |=> !drive) else $error("precharge passed limit");
  chk_gate_pass: assert property (
    !$past(i_rst) |-> o_gate_drive == $past(i_gate_req))
    else $error("gate pass through mismatch");
  chk_gain_range: assert property (
    o_primary_photo_amp_gain < `GAIN_SEL_W'(`GAIN_STEPS))
    else $error("gain beyond last step");

endmodule : led_illumination_drive_sequencer

// File: ctrl_model.sv
// Display controller model: frames one colour bit slice.
// Assumes led_drive_pkg compiled first; one clock, sync reset.
`timescale 1ns/100ps

module ctrl_model
  import led_drive_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic [3:0] i_chan,
  input  wire logic [7:0] i_dis_len,
  input  wire logic [7:0] i_pre_len,
  output gate_drive_t     o_gate_req,
  output logic            o_drive_request
);
  logic [1:0] phase;
  logic [7:0] cnt;

  // slice lasts while start is held
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || !i_start) begin
      phase <= 2'h0;
      cnt   <= 8'h00;
    end else if (phase == 2'h0) begin
      phase <= 2'h1;
      cnt   <= i_dis_len - 8'h01;
    end else if (phase != 2'h3 && cnt == 8'h00) begin
      phase <= phase + 2'h1;
      cnt   <= i_pre_len - 8'h01;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end

  always_comb begin
    o_gate_req.dissipative_shunt_enable = (phase == 2'h1);
    o_gate_req.low_res_shunt_enable     = (phase == 2'h2);
    o_gate_req.led_channel_select = (phase == 2'h3) ? i_chan : 4'h0;
    o_drive_request               = (phase != 2'h0);
  end
endmodule : ctrl_model

// File: led_illumination_drive_sequencer_tb.sv
// Bench for the drive sequencer with a controller model.
// Assumes package, design and ctrl_model are compiled first.
`timescale 1ns/100ps

module led_illumination_drive_sequencer_tb
  import led_drive_pkg::*;
;
  localparam logic [7:0] OFF_LEN = 8'h05;
  logic         i_ref_clk = 1'b0;
  logic         i_rst = 1'b1;
  logic         pulsed = 1'b0;
  logic [3:0]   gain = 4'h0;
  logic         cmp = 1'b0;
  logic         lim = 1'b0;
  logic         start = 1'b0;
  logic [3:0]   chan = 4'h0;
  color_set_t   cs [4];
  gate_drive_t  gate_req;
  gate_drive_t  gate;
  logic         req, drv, sync, cap, foi;
  logic [11:0]  fbd;
  logic [9:0]   limd;
  logic [3:0]   trim, gout;
  drive_state_t st;
  int           err_count = 0;
  int           comparisons = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  ctrl_model ctrl_model_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_start(start), .i_chan(chan), .i_dis_len(8'h04),
    .i_pre_len(8'h08), .o_gate_req(gate_req), .o_drive_request(req));

  led_illumination_drive_sequencer led_illumination_drive_sequencer_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_pulsed_light_operation(pulsed), .i_off_len(OFF_LEN),
    .i_gain_sel(gain), .i_color_set(cs), .i_gate_req(gate_req),
    .i_drive_request(req), .i_comparator(cmp), .i_limit_reached(lim),
    .o_buck_drive_enable(drv), .o_sync(sync), .o_output_cap_select(cap),
    .o_gate_drive(gate), .o_fb_dac(fbd), .o_peak_limit_dac(limd),
    .o_gain_trim(trim), .o_primary_photo_amp_gain(gout),
    .o_forced_off_interval(foi), .o_state(st));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task report_and_stop;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc

  // Bounded wait for a state, fatal to the run on timeout
  task wait_state(input drive_state_t s);
    for (int k = 0; k < 20 && st !== s; k++) cyc(1);
    if (st !== s) begin
      check("state wait", st, s);
      report_and_stop();
    end
  endtask : wait_state

  // Blanking then light, with the selected colour settings
  task run_slice(input logic [3:0] c, input int x, input drive_state_t l);
    @(posedge i_ref_clk);
    lim   <= 1'b0;
    cmp   <= 1'b1;
    chan  <= c;
    start <= 1'b1;
    wait_state(ST_DISSIPATE);
    cyc(2);
    check("dissipate", gate.dissipative_shunt_enable, 1'h1);
    check("select off", gate.led_channel_select, 4'h0);
    check("drive dis", drv, 1'h0);
    wait_state(ST_PRECHARGE);
    cyc(1);
    check("drive pre", drv, 1'h1);
    check("low shunt", gate.low_res_shunt_enable, 1'h1);
    @(posedge i_ref_clk);
    lim <= 1'b1;
    cyc(3);
    check("drive limit", drv, 1'h0);
    wait_state(l);
    check("shunt off", gate.low_res_shunt_enable, 1'h0);
    check("select", gate.led_channel_select, c);
    check("fb dac", fbd, cs[x].fb_ref);
    check("limit dac", limd, cs[x].limit);
    check("trim", trim, cs[x].trim);
    check("cap", cap, l == ST_PULSED);
  endtask : run_slice

  task stop_slice;
    @(posedge i_ref_clk);
    start <= 1'b0;
    cyc(2);
    check("idle", st, ST_IDLE);
    check("drive idle", drv, 1'h0);
  endtask : stop_slice

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task scen_colors;
    logic [3:0] sel [5];
    int         idx [5];
    sel = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
    idx = '{0, 1, 2, 3, 1};
    for (int i = 0; i < 5; i++) begin
      run_slice(sel[i], idx[i], ST_HYSTERETIC);
      stop_slice();
    end
  endtask : scen_colors

  task scen_forced_off;
    int n;
    n = 0;
    run_slice(4'h1, 0, ST_HYSTERETIC);
    cyc(4);
    check("drive on", drv, 1'h1);
    @(posedge i_ref_clk);
    cmp <= 1'b0;
    @(posedge i_ref_clk);
    cmp <= 1'b1;
    cyc(2);
    check("drive off", drv, 1'h0);
    check("forced", st, ST_FORCED_OFF);
    while (st === ST_FORCED_OFF && n < 300) begin
      check("drive held", drv, 1'h0);
      check("sync", sync, 1'h1);
      check("forced flag", foi, 1'h1);
      n++;
      cyc(1);
    end
    check("off length", n, OFF_LEN + 8'h01);
    check("sync end", sync, 1'h0);
    check("forced end", foi, 1'h0);
    cyc(2);
    check("drive back", drv, 1'h1);
    stop_slice();
  endtask : scen_forced_off

  task scen_pulsed;
    @(posedge i_ref_clk);
    pulsed <= 1'b1;
    cyc(2);
    check("cap pulsed", cap, 1'h1);
    run_slice(4'h2, 1, ST_PULSED);
    cyc(2);
    check("drive pulsed", drv, 1'h1);
    @(posedge i_ref_clk);
    cmp <= 1'b0;
    cyc(3);
    check("drive follow", drv, 1'h0);
    stop_slice();
    @(posedge i_ref_clk);
    pulsed <= 1'b0;
    cyc(1);
    check("cap steady", cap, 1'h0);
  endtask : scen_pulsed

  task scen_gain;
    logic [3:0] g [5];
    logic [3:0] e [5];
    g = '{4'h0, 4'h7, 4'hD, 4'hE, 4'hF};
    e = '{4'h0, 4'h7, 4'hD, 4'hD, 4'hD};
    for (int i = 0; i < 5; i++) begin
      @(posedge i_ref_clk);
      gain <= g[i];
      cyc(1);
      check("gain", gout, e[i]);
    end
  endtask : scen_gain

  initial begin
    for (int c = 0; c < 4; c++) begin
      cs[c].fb_ref = 12'hA50 + 12'(c);
      cs[c].limit  = 10'h155 + 10'(c);
      cs[c].trim   = 4'hF - 4'(c * 5);
    end
    cyc(5);
    check("reset state", st, ST_IDLE);
    check("reset out", {drv, sync, cap, gate}, 16'h0000);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    scen_gain();
    scen_colors();
    scen_forced_off();
    scen_pulsed();
    report_and_stop();
  end
endmodule : led_illumination_drive_sequencer_tb
